// ### src/led_shift_driver.sv
// twelve channel serial-in parallel-out led driver with storage latch and gated drains
`timescale 1ns/1ps
// Notes on behaviour
// - twelve stage shift register feeds storage register
// - shift on shift rise, latch on latch rise
// - storage reaches buffers only while clear high
// - clear low zeroes the shift, storage, buffer and cascade registers; thermal state is kept
// - cascade output changes on shift clock fall
// - enable high forces all buffer bits low
// - enable low: buffers follow storage transparently
// - buffer one sinks current, zero is off
// - over trip temperature, all drains off
// - resume only below release temperature
// - drains change at latch clock rise
module led_shift_driver
  import led_shift_pkg::*;
#(
  parameter int unsigned CH = NUM_CH     // channel count
) (
  // system clock and reset
  input  wire logic              CLK_SYS,
  input  wire logic              RST_N,
  // serial link pins from the controller
  input  wire logic              SHIFT_CLK,
  input  wire logic              LATCH_CLK,
  input  wire logic              SERIAL_DATA_IN,
  input  wire logic              CLEAR_N,
  input  wire logic              OUT_EN_N,
  // junction temperature code in deg C
  input  wire logic [TEMP_W-1:0] JUNCTION_TEMP,
  // drains and cascade
  output logic      [CH-1:0]     DRAIN_ON,
  output logic                   CASCADE_DATA_OUT,
  output logic                   THERMAL_SHUTDOWN
);

  pins_t             pins_meta_reg;      // first stage, read only by second
  pins_t             pins_reg;           // synchronised pins
  pins_t             pins_dly_reg;       // previous sample for edge finding
  logic [TEMP_W-1:0] temp_meta_reg;      // temperature first stage
  logic [TEMP_W-1:0] temp_reg;           // temperature synchronised
  logic [TEMP_W-1:0] temp_dly_reg;       // previous synchronised code
  logic [TEMP_W-1:0] temp_ok_reg;        // code seen twice alike, fed to trip compare
  logic [CH-1:0]     shift_reg;          // serial stages
  logic [CH-1:0]     store_reg;          // storage latch
  logic              store_load_reg;     // storage just loaded, offer it to the buffer
  logic [CH-1:0]     buf_data_reg [2];   // two-entry buffer toward drains
  logic [1:0]        buf_cnt_reg;        // occupied entries
  logic              buf_rd_reg;         // read pointer
  logic              buf_wr_reg;         // write pointer
  logic [CH-1:0]     out_buf_reg;        // output buffer image
  logic              cascade_reg;        // falling edge retimed last stage
  therm_state_t      therm_reg;          // thermal state
  logic              shift_rise;         // shift clock rising edge
  logic              shift_fall;         // shift clock falling edge
  logic              latch_rise;         // latch clock rising edge
  logic              clr_now;            // clear seen on synced pin
  logic              buf_in_valid;       // new word offered to buffer
  logic              buf_in_ready;       // buffer has room
  logic              buf_out_valid;      // buffer holds a word
  logic              buf_out_ready;      // consumer takes it
  logic [CH-1:0]     buf_out_data;       // word at buffer head
  logic [CH-1:0]     drain_next;         // next drain value

  // rise of a synchronised level against its previous sample
  function automatic logic level_rose(input logic now_lvl, input logic was_lvl);
    return now_lvl & ~was_lvl;
  endfunction

  // edge and level decode from the second stage only
  assign shift_rise    = level_rose(pins_reg.shift_clk, pins_dly_reg.shift_clk);
  assign shift_fall    = level_rose(pins_dly_reg.shift_clk, pins_reg.shift_clk);
  assign latch_rise    = level_rose(pins_reg.latch_clk, pins_dly_reg.latch_clk);
  // clear is seen the cycle the synced level drops, no link edge needed
  assign clr_now       = ~pins_reg.clear_n;
  // the buffer takes the storage word one cycle after it was loaded
  assign buf_in_valid  = store_load_reg & ~clr_now;
  assign buf_in_ready  = (buf_cnt_reg != BUF_DEPTH);
  assign buf_out_valid = (buf_cnt_reg != 2'h0);
  assign buf_out_ready = 1'b1;          // output buffer always accepts one per cycle
  assign buf_out_data  = buf_data_reg[buf_rd_reg];

  // two flip-flop synchronisers for every pin
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      pins_meta_reg <= '0;
      pins_reg      <= '0;
      pins_dly_reg  <= '0;
      temp_meta_reg <= '0;
      temp_reg      <= '0;
    end else begin
      pins_meta_reg <= pins_t'({SHIFT_CLK, LATCH_CLK, SERIAL_DATA_IN, CLEAR_N, OUT_EN_N});
      pins_reg      <= pins_meta_reg;
      pins_dly_reg  <= pins_reg;
      // code bits may land in different cycles; filtered further down
      temp_meta_reg <= JUNCTION_TEMP;
      temp_reg      <= temp_meta_reg;
    end
  end

  // serial shift chain
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      shift_reg <= ZERO_WORD;
    end else if (clr_now) begin
      shift_reg <= ZERO_WORD;
    end else if (shift_rise) begin
      shift_reg <= {shift_reg[CH-2:0], pins_reg.serial_data_in};
    end
  end

  // storage latch loads the whole chain in parallel
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      store_reg <= ZERO_WORD;
    end else if (clr_now) begin
      store_reg <= ZERO_WORD;
    end else if (latch_rise) begin
      store_reg <= shift_reg;
    end
  end

  // load strobe one cycle late, so the buffer reads the storage register itself
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      store_load_reg <= 1'b0;
    end else if (clr_now) begin
      store_load_reg <= 1'b0;
    end else begin
      store_load_reg <= latch_rise;
    end
  end

  // two-entry buffer carrying latched words to the output stage
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      buf_cnt_reg     <= 2'h0;
      buf_rd_reg      <= 1'b0;
      buf_wr_reg      <= 1'b0;
      buf_data_reg[0] <= ZERO_WORD;
      buf_data_reg[1] <= ZERO_WORD;
    end else if (clr_now) begin
      // flush so no stale word reaches the drains after clear
      buf_cnt_reg <= 2'h0;
      buf_rd_reg  <= 1'b0;
      buf_wr_reg  <= 1'b0;
    end else begin
      if (buf_in_valid && buf_in_ready) begin
        buf_data_reg[buf_wr_reg] <= store_reg;
        buf_wr_reg               <= ~buf_wr_reg;
      end
      if (buf_out_valid && buf_out_ready) begin
        buf_rd_reg <= ~buf_rd_reg;
      end
      case ({buf_in_valid && buf_in_ready, buf_out_valid && buf_out_ready})
        2'b10:   buf_cnt_reg <= buf_cnt_reg + 2'h1;
        2'b01:   buf_cnt_reg <= buf_cnt_reg - 2'h1;
        default: buf_cnt_reg <= buf_cnt_reg;
      endcase
    end
  end

  // output buffer image follows the latch only while clear is high
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      out_buf_reg <= ZERO_WORD;
    end else if (clr_now) begin
      out_buf_reg <= ZERO_WORD;
    end else if (buf_out_valid) begin
      out_buf_reg <= buf_out_data;
    end
  end

  // temperature code moves on only after two equal samples, so a code whose
  // bits crossed in different cycles never reaches the trip compare
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      temp_dly_reg <= '0;
      temp_ok_reg  <= '0;
    end else begin
      temp_dly_reg <= temp_reg;
      if (temp_reg == temp_dly_reg) begin
        temp_ok_reg <= temp_reg;            // costs two cycles of latency
      end
    end
  end

  // thermal hysteresis
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      therm_reg <= TH_RUN;
    end else begin
      case (therm_reg)
        TH_RUN:  if (temp_ok_reg > TEMP_TRIP_C) therm_reg <= TH_SHUT;
        TH_SHUT: if (temp_ok_reg < TEMP_REL_C) therm_reg <= TH_RUN;
        default: therm_reg <= TH_RUN;
      endcase
    end
  end

  // gating: enable, clear and thermal state all force drains off
  always_comb begin
    drain_next = out_buf_reg;
    if (pins_reg.out_en_n) begin
      drain_next = ZERO_WORD;
    end
    if (clr_now || therm_reg == TH_SHUT) begin
      drain_next = ZERO_WORD;
    end
  end

  // drains: one sinks current, zero is off
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      DRAIN_ON         <= ZERO_WORD;
      THERMAL_SHUTDOWN <= 1'b0;
    end else begin
      DRAIN_ON         <= drain_next;
      THERMAL_SHUTDOWN <= (therm_reg == TH_SHUT);
    end
  end

  // cascade: last stage retimed on the shift clock fall
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      cascade_reg <= 1'b0;
    end else if (clr_now) begin
      cascade_reg <= 1'b0;
    end else if (shift_fall) begin
      cascade_reg <= shift_reg[CH-1];
    end
  end

  assign CASCADE_DATA_OUT = cascade_reg;

endmodule

// ### src/led_shift_pkg.sv
// package: widths, thermal thresholds and carrier types for the led shift driver
package led_shift_pkg;
  localparam int unsigned         NUM_CH        = 12;                 // drain channels
  localparam int unsigned         TEMP_W        = 9;                  // junction temperature code width, deg C
  localparam logic [TEMP_W-1:0]   TEMP_TRIP_C   = 9'h0AF;             // 175 C trip point
  localparam logic [TEMP_W-1:0]   TEMP_REL_C    = 9'h0A0;             // 160 C release point
  localparam logic [NUM_CH-1:0]   ZERO_WORD     = 12'h000;            // cleared register value
  localparam logic [1:0]          SYNC_ZERO     = 2'h0;               // synchroniser reset value
  localparam logic [1:0]          BUF_DEPTH     = 2'h2;               // entries in the latch buffer

  // synchronised control pins travelling together
  typedef struct packed {
    logic shift_clk;
    logic latch_clk;
    logic serial_data_in;
    logic clear_n;
    logic out_en_n;
  } pins_t;

  // thermal protection state
  typedef enum logic [0:0] {
    TH_RUN  = 1'b0,
    TH_SHUT = 1'b1
  } therm_state_t;
endpackage

// ### verif/ctrl_model.sv
// controller model that shifts and latches words
`timescale 1ns/1ps
module ctrl_model
  import led_shift_pkg::*;
(
  // system clock
  input  wire logic clk,
  // link pins
  output logic      shift_clk,
  output logic      latch_clk,
  output logic      serial_data_in
);
  initial begin
    shift_clk = 1'b0;
    latch_clk = 1'b0;
    serial_data_in = 1'b0;
  end
  // half of the 400 ns link period
  task automatic half();
    repeat (4) @(posedge clk);
  endtask
  // first bit sent lands on the top drain
  task automatic send(input logic [NUM_CH-1:0] w);
    @(posedge clk); // pins move only at a clock edge
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      serial_data_in <= w[i];
      half();
      shift_clk <= 1'b1;
      half();
      shift_clk <= 1'b0;
    end
    half();
    serial_data_in <= ~w[0]; // stale data shown inverted
  endtask
  // one latch pulse, then room for the drains to land
  task automatic pulse();
    @(posedge clk); // caller may stand off the edge
    latch_clk <= 1'b1;
    half();
    latch_clk <= 1'b0;
    half();
    half();
  endtask
endmodule

// ### verif/led_shift_driver_assertions.sv
// port checker for the led shift driver
`timescale 1ns/1ps
module led_shift_driver_chk
  import led_shift_pkg::*;
#(
  parameter int unsigned CH = NUM_CH // channel count
) (
  // clock and reset
  input wire logic              CLK_SYS,
  input wire logic              RST_N,
  // link pins
  input wire logic              SHIFT_CLK,
  input wire logic              LATCH_CLK,
  input wire logic              CLEAR_N,
  input wire logic              OUT_EN_N,
  input wire logic [TEMP_W-1:0] JUNCTION_TEMP,
  // outputs
  input wire logic [CH-1:0]     DRAIN_ON,
  input wire logic              CASCADE_DATA_OUT,
  input wire logic              THERMAL_SHUTDOWN
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  // counts allow for the pin synchronisers
  chk_clear_zero: assert property (!CLEAR_N [*6] |-> DRAIN_ON == '0 && !CASCADE_DATA_OUT)
    else $error("clear left outputs set");
  chk_gate_off: assert property (OUT_EN_N [*6] |-> DRAIN_ON == '0)
    else $error("drains on while gated");
  chk_hot_off: assert property (THERMAL_SHUTDOWN [*4] |-> DRAIN_ON == '0)
    else $error("drains on while hot");
  // temperature path adds two cycles for the equal-sample filter
  chk_trip_set: assert property ((JUNCTION_TEMP > TEMP_TRIP_C) [*7] |-> THERMAL_SHUTDOWN)
    else $error("no trip above threshold");
  chk_trip_hold: assert property ((JUNCTION_TEMP >= TEMP_REL_C) [*5] ##0 THERMAL_SHUTDOWN |=> THERMAL_SHUTDOWN)
    else $error("early release");
  chk_cool_run: assert property ((JUNCTION_TEMP < TEMP_REL_C) [*7] |-> !THERMAL_SHUTDOWN)
    else $error("no release when cool");
  // a rise may only follow a shift clock fall
  chk_casc_fall: assert property ($rose(CASCADE_DATA_OUT) |-> !$past(SHIFT_CLK, 2))
    else $error("cascade moved while shift high");
  chk_drain_hold: assert property ((!LATCH_CLK && !OUT_EN_N && CLEAR_N && !THERMAL_SHUTDOWN) [*8]
    |-> $stable(DRAIN_ON))
    else $error("drains moved without latch");
  cover property (THERMAL_SHUTDOWN);
  cover property ($rose(CASCADE_DATA_OUT));
  cover property ($rose(LATCH_CLK) && !OUT_EN_N);
endmodule
bind led_shift_driver led_shift_driver_chk #(.CH(CH)) i_led_shift_driver_chk (.CLK_SYS, .RST_N,
  .SHIFT_CLK, .LATCH_CLK, .CLEAR_N, .OUT_EN_N, .JUNCTION_TEMP, .DRAIN_ON, .CASCADE_DATA_OUT, .THERMAL_SHUTDOWN);

// ### verif/tb.sv
// testbench for the led shift driver
`timescale 1ns/1ps
module tb
  import led_shift_pkg::*;
;
  logic              clk = 1'b0;       // 20 MHz
  logic              rst_n = 1'b0;     // sync reset
  logic              clear_n = 1'b0;   // held low from start
  logic              out_en_n = 1'b1;  // drains gated
  logic [TEMP_W-1:0] temp = 9'h019;    // cool
  logic              sck, lck, sdi;    // model pins
  logic [NUM_CH-1:0] drain;            // drains
  logic              casc, hot;        // cascade, shutdown
  int                fail_count = 0;   // mismatches
  int                compares = 0;     // comparisons
  always #25 clk = ~clk;
  ctrl_model i_ctrl_model (.clk(clk), .shift_clk(sck), .latch_clk(lck), .serial_data_in(sdi));
  led_shift_driver i_led_shift_driver (.CLK_SYS(clk), .RST_N(rst_n), .SHIFT_CLK(sck), .LATCH_CLK(lck),
    .SERIAL_DATA_IN(sdi), .CLEAR_N(clear_n), .OUT_EN_N(out_en_n), .JUNCTION_TEMP(temp),
    .DRAIN_ON(drain), .CASCADE_DATA_OUT(casc), .THERMAL_SHUTDOWN(hot));
  task automatic check(input string what, input logic [NUM_CH-1:0] seen, input logic [NUM_CH-1:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // let pipelines land, step off the edge
  task automatic settle();
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic t_load();
    @(posedge clk);
    out_en_n <= 1'b0;
    i_ctrl_model.send(12'hA5C);
    settle();
    check("drain before latch", drain, 12'h000);
    check("cascade", {11'h000, casc}, 12'h001);
    i_ctrl_model.pulse();
    settle();
    check("drain latched", drain, 12'hA5C);
  endtask
  task automatic t_gate();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      out_en_n <= ~out_en_n;
      settle();
      check("drain gated", drain, out_en_n ? 12'h000 : 12'hA5C);
    end
  endtask
  task automatic t_heat();
    logic [TEMP_W-1:0] tv[4] = '{9'h0AF, 9'h0B0, 9'h0A0, 9'h09F};
    logic [3:0]        sd = 4'b0110;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      temp <= tv[i];
      settle();
      check("shutdown", {11'h000, hot}, {11'h000, sd[i]});
      check("drain hot", drain, sd[i] ? 12'h000 : 12'hA5C);
    end
  endtask
  task automatic t_clear();
    @(posedge clk);
    clear_n <= 1'b0;
    settle();
    check("drain cleared", drain, 12'h000);
    check("cascade cleared", {11'h000, casc}, 12'h000);
    @(posedge clk);
    clear_n <= 1'b1;
    settle();
    check("storage cleared", drain, 12'h000);
    i_ctrl_model.pulse();
    settle();
    check("shift cleared", drain, 12'h000);
  endtask
  task automatic conclude();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    conclude();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    clear_n <= 1'b1;
    t_load();
    t_gate();
    t_heat();
    t_clear();
    conclude();
  end
endmodule
